//--- pkg/lps_defines.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * sensor's upper register bank.
 * Assumes a 125 MHz core clock and an external byte-wide register port.
 */
// Operation
// - Wait stretch bit set makes every wait period twelve times longer.
// - With proximity enabled, a proximity cycle follows every light cycle.
// - Each proximity cycle emits exactly the programmed pulse count at 62.5 kHz.
// - Proximity interval timed from light integration setting, even with light off.
// - Control bits 7:6 set LED drive current, 100 mA down to 12.5 mA.
// - Control bits 5:4 pick photodiode zero, one or both; 00 reserved.
// - Control bits 1:0 set light gain 1x, 8x, 16x or 120x.
// - Read-only identification byte at 0x12, unchanged by writes.
// - Status bit 5 shows proximity interrupt; status is read-only.
// - Status bit 4 shows light interrupt.
// - Status bit 0 sets once a light integration has completed.
// - Light results are 16-bit, low byte first, at 0x14 to 0x17.
// - Low-byte read captures high byte; next high-byte read returns it.
// - Captured high byte stays coherent across later integrations.
// - Proximity result at 0x18/0x19 with the same high-byte capture.
// - Interrupt pin is open drain: drives low only when asserted.
// - Unstretched wait counts in 2.72 ms steps, setting as two's complement.
// - Light interrupt when channel zero leaves the low/high threshold window.
`ifndef LPS_DEFINES_SVH
`define LPS_DEFINES_SVH

// ====================================================================
// Register offsets
`define LPS_OFS_CONFIG      8'h0D
`define LPS_OFS_PULSE       8'h0E
`define LPS_OFS_CONTROL     8'h0F
`define LPS_OFS_ID          8'h12
`define LPS_OFS_STATUS      8'h13
`define LPS_OFS_CH0_LO      8'h14
`define LPS_OFS_CH0_HI      8'h15
`define LPS_OFS_CH1_LO      8'h16
`define LPS_OFS_CH1_HI      8'h17
`define LPS_OFS_PROX_LO     8'h18
`define LPS_OFS_PROX_HI     8'h19

// ====================================================================
// Field positions and masks
`define LPS_CFG_STRETCH_BIT 1
`define LPS_CFG_MASK        8'h02
`define LPS_CTL_MASK        8'hF3
`define LPS_ST_PROX_BIT     5
`define LPS_ST_LIGHT_BIT    4
`define LPS_ST_VALID_BIT    0

// ====================================================================
// Reset values and arbitrary identity
`define LPS_RST_BYTE        8'h00
`define LPS_RST_CONTROL     8'h10
`define LPS_ID_VALUE        8'h5A

// ====================================================================
// Timing: step of 2.72 ms in ns, pulse period 16 us in ns, clock 8 ns
`define LPS_CLK_NS          8
`define LPS_STEP_NS         2720000
`define LPS_PULSE_NS        16000
`define LPS_STRETCH         12
`define LPS_STEP_CYC        (`LPS_STEP_NS / `LPS_CLK_NS)
`define LPS_PULSE_CYC       (`LPS_PULSE_NS / `LPS_CLK_NS)
`define LPS_PULSE_HALF      (`LPS_PULSE_CYC / 2)

`endif

//--- pkg/lps_pkg.sv
/*
 * Types shared by the sensor register bank.
 * Assumes lps_defines.svh supplies all numeric constants.
 */
package lps_pkg;

    typedef enum logic [1:0] {
        LPS_IDLE  = 2'b00,
        LPS_LIGHT = 2'b01,
        LPS_PROX  = 2'b11,
        LPS_WAIT  = 2'b10
    } lps_phase_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lps_bus_req_t;

    typedef struct packed {
        logic [15:0] ch0;
        logic [15:0] ch1;
        logic [15:0] prox;
        logic        light_done;
        logic        prox_done;
    } lps_result_t;

    typedef struct packed {
        logic [1:0] drive;
        logic [1:0] diode;
        logic [1:0] gain;
        logic       led;
        logic       int_n_oe;
        logic       light_cycle;
        logic       prox_cycle;
    } lps_analog_t;

endpackage

//--- core/lps_shadow.sv
/*
 * Three-entry shadow store of result high bytes captured on low-byte reads.
 * Assumes capture and read strobes are one-cycle pulses on i_clk.
 */
`include "lps_defines.svh"

module lps_shadow (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Capture side
    input  wire logic       i_wr,
    input  wire logic [1:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    // Read side
    input  wire logic [1:0] i_raddr,
    output logic      [7:0] o_rdata
);

    logic [7:0] mem [0:2];

    // ====================================================================
    // Storage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 3; k++) begin
                mem[k] <= `LPS_RST_BYTE;
            end
            o_rdata <= `LPS_RST_BYTE;
        end else begin
            if (i_wr && i_waddr != 2'h3) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= (i_raddr == 2'h3) ? `LPS_RST_BYTE : mem[i_raddr];
        end
    end

endmodule // lps_shadow

//--- core/lps_regs.sv
/*
 * Upper register bank of a light and proximity sensor: configuration,
 * pulse count, analog control, identification, status, result bytes with
 * high-byte shadowing, and the measurement sequencer's wait timing.
 * Assumes an external serial engine presents byte reads and writes as
 * one-cycle strobes; results arrive from the analog side, thresholds from the lower registers.
 */
`include "lps_defines.svh"

module lps_regs #(
    parameter int unsigned STEP_CYC  = `LPS_STEP_CYC,
    parameter int unsigned PULSE_CYC = `LPS_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    // Register port from the serial engine
    input  wire lps_pkg::lps_bus_req_t i_req,
    output logic               [7:0]  o_rdata,
    output logic                      o_rvalid,
    // Control inputs from lower registers
    input  wire logic                 i_light_en,
    input  wire logic                 i_prox_en,
    input  wire logic                 i_wait_en,
    input  wire logic          [7:0]  i_wait_period_setting,
    input  wire logic          [7:0]  i_light_integration_setting,
    input  wire logic         [15:0]  i_light_low_thresh,
    input  wire logic         [15:0]  i_light_high_thresh,
    input  wire logic                 i_prox_irq_flag,
    input  wire logic                 i_irq_clear,
    // Analog results
    input  wire lps_pkg::lps_result_t i_result,
    // Analog controls and interrupt pin; light interrupt and result-valid flags
    output lps_pkg::lps_analog_t      o_analog,
    output logic                      o_light_irq_flag,
    output logic                      o_light_result_valid
);

    typedef struct packed {
        logic [7:0]          cfg;
        logic [7:0]          pulses;
        logic [7:0]          ctl;
        logic [15:0]         ch0;
        logic [15:0]         ch1;
        logic [15:0]         prox;
        logic                valid;
        logic                light_irq;
        lps_pkg::lps_phase_t phase;
        logic [31:0]         tick;
        logic [8:0]          steps;
        logic [3:0]          stretch;
        logic [8:0]          pulse_left;
        logic [7:0]          rdata;
        logic                rvalid;
        logic [1:0]          rsel;
        logic                led;
    } lps_state_t;

    lps_state_t st;
    lps_state_t next_st;
    logic [7:0] shadow_rdata;
    logic       cap_wr;
    logic [1:0] cap_addr;
    logic [7:0] cap_data;
    logic [1:0] sh_raddr;

    // Maps an address to its shadow slot; 3 means no slot
    function automatic logic [1:0] lps_slot(input logic [7:0] a);
        unique case (a)
            `LPS_OFS_CH0_LO, `LPS_OFS_CH0_HI:   lps_slot = 2'h0;
            `LPS_OFS_CH1_LO, `LPS_OFS_CH1_HI:   lps_slot = 2'h1;
            `LPS_OFS_PROX_LO, `LPS_OFS_PROX_HI: lps_slot = 2'h2;
            default:                            lps_slot = 2'h3;
        endcase
    endfunction

    function automatic logic lps_is_high(input logic [7:0] a);
        lps_is_high = (a == `LPS_OFS_CH0_HI) || (a == `LPS_OFS_CH1_HI)
                   || (a == `LPS_OFS_PROX_HI);
    endfunction

    // ====================================================================
    // Shadow capture: the high byte is frozen at the low-byte read
    always_comb begin
        cap_wr   = i_req.rd && !lps_is_high(i_req.addr) && (lps_slot(i_req.addr) != 2'h3);
        cap_addr = lps_slot(i_req.addr);
        unique case (lps_slot(i_req.addr))
            2'h0:    cap_data = st.ch0[15:8];
            2'h1:    cap_data = st.ch1[15:8];
            2'h2:    cap_data = st.prox[15:8];
            default: cap_data = `LPS_RST_BYTE;
        endcase
        sh_raddr = lps_slot(i_req.addr);
    end

    lps_shadow u_shadow (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_wr    (cap_wr),
        .i_waddr (cap_addr),
        .i_wdata (cap_data),
        .i_raddr (sh_raddr),
        .o_rdata (shadow_rdata)
    );

    // ====================================================================
    // Next state
    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        next_st.rsel   = 2'h0;

        // Register writes; reserved bits are masked off
        if (i_req.wr) begin
            unique case (i_req.addr)
                `LPS_OFS_CONFIG:  next_st.cfg    = i_req.wdata & `LPS_CFG_MASK;
                `LPS_OFS_PULSE:   next_st.pulses = i_req.wdata;
                `LPS_OFS_CONTROL: next_st.ctl    = i_req.wdata & `LPS_CTL_MASK;
                default:          ;
            endcase
        end

        // Register reads: high bytes come from the shadow, with the same latency as st.rdata
        if (i_req.rd) begin
            next_st.rvalid = 1'b1;
            next_st.rsel   = lps_is_high(i_req.addr) ? 2'h1 : 2'h0;
            unique case (i_req.addr)
                `LPS_OFS_CONFIG:  next_st.rdata = st.cfg;
                `LPS_OFS_PULSE:   next_st.rdata = st.pulses;
                `LPS_OFS_CONTROL: next_st.rdata = st.ctl;
                `LPS_OFS_ID:      next_st.rdata = `LPS_ID_VALUE;
                `LPS_OFS_STATUS: begin
                    next_st.rdata = `LPS_RST_BYTE;
                    next_st.rdata[`LPS_ST_PROX_BIT]  = i_prox_irq_flag;
                    next_st.rdata[`LPS_ST_LIGHT_BIT] = st.light_irq;
                    next_st.rdata[`LPS_ST_VALID_BIT] = st.valid;
                end
                `LPS_OFS_CH0_LO:  next_st.rdata = st.ch0[7:0];
                `LPS_OFS_CH1_LO:  next_st.rdata = st.ch1[7:0];
                `LPS_OFS_PROX_LO: next_st.rdata = st.prox[7:0];
                default:          next_st.rdata = `LPS_RST_BYTE;
            endcase
        end

        // Result capture; the shadow keeps read coherence
        if (i_result.light_done) begin
            next_st.ch0   = i_result.ch0;
            next_st.ch1   = i_result.ch1;
            next_st.valid = 1'b1;
            if (i_result.ch0 < i_light_low_thresh || i_result.ch0 > i_light_high_thresh) begin
                next_st.light_irq = 1'b1;
            end
        end
        if (i_result.prox_done) begin
            next_st.prox = i_result.prox;
        end
        // Set wins over clear, even when the flag was already standing
        if (i_irq_clear && !(i_result.light_done
            && (i_result.ch0 < i_light_low_thresh || i_result.ch0 > i_light_high_thresh))) begin
            next_st.light_irq = 1'b0;
        end
        if (!i_light_en && !i_prox_en) begin
            next_st.valid = 1'b0;
        end

        // Measurement sequencer
        next_st.tick = st.tick + 32'd1;
        unique case (st.phase)
            lps_pkg::LPS_IDLE: begin
                next_st.tick = 32'd0;
                next_st.led  = 1'b0;
                if (i_light_en || i_prox_en) begin
                    next_st.phase = lps_pkg::LPS_LIGHT;
                    next_st.steps = 9'(9'h100 - {1'b0, i_light_integration_setting});
                end
            end
            lps_pkg::LPS_LIGHT: begin
                // Interval runs from the integration setting even if light is off
                if (st.tick == STEP_CYC - 1) begin
                    next_st.tick  = 32'd0;
                    next_st.steps = 9'(st.steps - 9'd1);
                    if (st.steps == 9'd1) begin
                        next_st.phase      = i_prox_en ? lps_pkg::LPS_PROX
                                                       : lps_pkg::LPS_WAIT;
                        next_st.pulse_left = {1'b0, st.pulses};
                        next_st.steps      = 9'(9'h100 - {1'b0, i_wait_period_setting});
                        next_st.stretch    = 4'd0;
                    end
                end
            end
            lps_pkg::LPS_PROX: begin
                // One LED pulse per period while pulses remain, high for the first half; the closing period has none
                next_st.led = (st.pulse_left != 9'd0) && (st.tick < PULSE_CYC / 2);
                if (st.tick == PULSE_CYC - 1) begin
                    next_st.tick = 32'd0;
                    if (st.pulse_left != 9'd0) begin
                        next_st.pulse_left = 9'(st.pulse_left - 9'd1);
                    end else begin
                        next_st.phase = lps_pkg::LPS_WAIT;
                    end
                end
            end
            lps_pkg::LPS_WAIT: begin
                next_st.led = 1'b0;
                if (!i_wait_en) begin
                    next_st.phase = lps_pkg::LPS_IDLE;
                end else if (st.tick == STEP_CYC - 1) begin
                    next_st.tick = 32'd0;
                    if (st.cfg[`LPS_CFG_STRETCH_BIT]
                        && st.stretch != 4'(`LPS_STRETCH - 1)) begin
                        next_st.stretch = 4'(st.stretch + 4'd1);
                    end else begin
                        next_st.stretch = 4'd0;
                        next_st.steps   = 9'(st.steps - 9'd1);
                        if (st.steps == 9'd1) begin
                            next_st.phase = lps_pkg::LPS_IDLE;
                        end
                    end
                end
            end
        endcase
    end

    // ====================================================================
    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st       <= '0;
            st.ctl   <= `LPS_RST_CONTROL;
            st.phase <= lps_pkg::LPS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ====================================================================
    // Outputs, all registered
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_analog             <= '0;
            o_rdata              <= `LPS_RST_BYTE;
            o_rvalid             <= 1'b0;
            o_light_irq_flag     <= 1'b0;
            o_light_result_valid <= 1'b0;
        end else begin
            o_analog.drive       <= st.ctl[7:6];
            o_analog.diode       <= st.ctl[5:4];
            o_analog.gain        <= st.ctl[1:0];
            o_analog.led         <= st.led;
            o_analog.int_n_oe    <= st.light_irq || i_prox_irq_flag;
            o_analog.light_cycle <= st.phase == lps_pkg::LPS_LIGHT && i_light_en;
            o_analog.prox_cycle  <= st.phase == lps_pkg::LPS_PROX;
            o_rdata              <= st.rsel[0] ? shadow_rdata : st.rdata;
            o_rvalid             <= st.rvalid;
            o_light_irq_flag     <= st.light_irq;
            o_light_result_valid <= st.valid;
        end
    end

endmodule // lps_regs

//--- tb/lps_regs_assertions.sv
/* Port checker for lps_regs, bound below.
   Assumes the short pulse period used in simulation. */
`include "lps_defines.svh"

module lps_regs_assertions #(
    parameter int unsigned PULSE_CYC = 8
) (
    // Watched ports
    input wire logic                 i_clk,
    input wire logic                 i_rst,
    input wire lps_pkg::lps_bus_req_t i_req,
    input wire logic [7:0]           o_rdata,
    input wire logic                 o_rvalid,
    input wire logic                 i_light_en,
    input wire lps_pkg::lps_result_t i_result,
    input wire lps_pkg::lps_analog_t o_analog,
    input wire logic                 o_light_irq_flag,
    input wire logic                 o_light_result_valid
);
    // ==========================================
    // Helpers
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    int unsigned led_run;
    always_ff @(posedge i_clk) begin
        if (i_rst || !o_analog.led) led_run <= 0;
        else led_run <= led_run + 1;
    end
    sequence s_rd(a);
        i_req.rd && i_req.addr == a;
    endsequence
    property p_ctl;
        logic [7:0] v;
        (i_req.wr && i_req.addr == 8'h0F, v = i_req.wdata) |-> ##2
            ({o_analog.drive, o_analog.diode, o_analog.gain} == {v[7:4], v[1:0]});
    endproperty
    // ==========================================
    // Checks
    chk_rd_answer: assert property (i_req.rd |-> ##2 o_rvalid)
        else $error("read answer missing");
    chk_rd_cause: assert property (o_rvalid |-> $past(i_req.rd, 2))
        else $error("answer without read");
    chk_id_value: assert property (s_rd(8'h12) |-> ##2 o_rdata == `LPS_ID_VALUE)
        else $error("identification wrong");
    chk_status_resv: assert property (s_rd(8'h13) |-> ##2
        (o_rdata[7:6] == 2'b00 && o_rdata[3:1] == 3'b000)) else $error("status reserved set");
    chk_cfg_resv: assert property (s_rd(8'h0D) |-> ##2 (o_rdata & 8'hFD) == 8'h00)
        else $error("config reserved set");
    chk_ctl_fields: assert property (p_ctl)
        else $error("analog fields wrong");
    chk_led_width: assert property ($fell(o_analog.led) |-> led_run == PULSE_CYC / 2)
        else $error("led pulse width wrong");
    chk_led_phase: assert property (o_analog.led |->
        (o_analog.prox_cycle || $past(o_analog.prox_cycle))) else $error("led outside phase");
    chk_valid_set: assert property (i_result.light_done && i_light_en |->
        ##[1:2] o_light_result_valid) else $error("valid not set");
    chk_irq_pin: assert property (o_light_irq_flag |-> ##[0:2] o_analog.int_n_oe)
        else $error("interrupt pin not driven");
endmodule // lps_regs_assertions

bind lps_regs lps_regs_assertions #(.PULSE_CYC(PULSE_CYC)) u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_light_en(i_light_en), .i_result(i_result), .o_analog(o_analog),
    .o_light_irq_flag(o_light_irq_flag), .o_light_result_valid(o_light_result_valid));

//--- tb/lps_host.sv
/* Host model issuing register reads and writes.
   Assumes requests launch 1 ns after the rising edge. */
module lps_host (
    // Clock
    input  wire logic                  i_clk,
    // Register port
    output lps_pkg::lps_bus_req_t      o_req,
    input  wire logic [7:0]            i_rdata,
    input  wire logic                  i_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_req = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        if (a == 8'h0D) d = d & 8'h02;
        if (a == 8'h0F) d = d & 8'hF3;
        o_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        #1;
        // Released lines show a changing pattern, not the last value
        o_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge i_clk);
        #1;
        o_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        #1;
        o_req = '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
        for (int n = 0; n < 8 && !ok; n++) begin
            @(posedge i_clk);
            #1;
            if (i_rvalid === 1'b1) begin
                ok = 1'b1;
                d = i_rdata;
            end
        end
    endtask
endmodule // lps_host

//--- tb/light_prox_sensor_regs_test.sv
/* Self-checking bench for lps_regs with a host model.
   Assumes short step and pulse counts to keep the run brief. */
module light_prox_sensor_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rst = 1, i_light_en = 0, i_prox_en = 0, i_wait_en = 0;
    logic i_prox_irq_flag = 0, i_irq_clear = 0, o_rvalid, o_light_irq_flag, ok, fol;
    logic o_light_result_valid;
    logic [7:0] i_wait_period_setting = 8'hFF, i_light_integration_setting = 8'hFF;
    logic [7:0] o_rdata, d, c;
    logic [15:0] i_light_low_thresh = 16'h1000, i_light_high_thresh = 16'h8000, e;
    lps_pkg::lps_bus_req_t i_req;
    lps_pkg::lps_result_t i_result = '0;
    lps_pkg::lps_analog_t o_analog;
    logic [31:0] seed = 32'h483721F0, v;
    logic [7:0] mdl [0:31];
    logic [7:0] regs [4] = '{8'h0D, 8'h0E, 8'h0F, 8'h12};
    int err_count, checks_done, len, gap0, gap1, np;

    lps_regs #(.STEP_CYC(20), .PULSE_CYC(8)) uut (.*);
    lps_host u_host (.i_clk(i_clk), .o_req(i_req), .i_rdata(o_rdata), .i_rvalid(o_rvalid));

    initial forever #4 i_clk = ~i_clk;
    initial begin
        repeat (100000) @(posedge i_clk);
        err_count++;
        print_verdict();
    end

    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a);
        u_host.rd(a, d, ok);
        if (!ok) begin
            err_count++;
            print_verdict();
        end
    endtask
    task automatic pulse(input bit clr);
        @(posedge i_clk);
        #1;
        if (clr) i_irq_clear = 1;
        else {i_result.light_done, i_result.prox_done} = 2'b11;
        @(posedge i_clk);
        #1;
        {i_irq_clear, i_result.light_done, i_result.prox_done} = 3'b000;
    endtask
    // One full sequencer round: light phase length, pulses, gap to next round
    task automatic measure(output int ln, output int gp, output int pl, output logic f);
        int n;
        logic led_d;
        {n, ln, gp, pl, led_d} = '0;
        while (o_analog.light_cycle !== 1'b0 && n < 9000) begin @(posedge i_clk); #1; n++; end
        while (o_analog.light_cycle !== 1'b1 && n < 9000) begin @(posedge i_clk); #1; n++; end
        while (o_analog.light_cycle === 1'b1 && n < 9000) begin
            @(posedge i_clk);
            #1;
            ln++;
            n++;
        end
        f = o_analog.prox_cycle;
        while (o_analog.prox_cycle === 1'b1 && n < 9000) begin
            if (o_analog.led && !led_d) pl++;
            led_d = o_analog.led;
            @(posedge i_clk);
            #1;
            n++;
        end
        while (o_analog.light_cycle !== 1'b1 && n < 9000) begin @(posedge i_clk); #1; gp++; n++; end
        if (n >= 9000) begin
            err_count++;
            print_verdict();
        end
    endtask

    // ==========================================
    // Main sequence
    initial begin
        mdl = '{default: 8'h00};
        mdl[5'h0F] = 8'h10;
        mdl[5'h12] = 8'h5A;
        repeat (4) @(posedge i_clk);
        #1 i_rst = 0;
        for (int i = 0; i < 5; i++) begin
            if (i > 0) begin
                v = rnd();
                c = 8'(i - 1);
                mdl[5'h0D] = v[7:0] & 8'h02;
                mdl[5'h0E] = v[15:8];
                mdl[5'h0F] = {c[1:0], (c == 0) ? 2'b01 : c[1:0], 2'b00, c[1:0]};
                u_host.wr(8'h0D, v[7:0]);
                u_host.wr(8'h0E, v[15:8]);
                u_host.wr(8'h0F, mdl[5'h0F] | 8'h0C);
                u_host.wr(8'h12, v[23:16]);
            end
            foreach (regs[j]) begin
                rd(regs[j]);
                check("register", d, mdl[regs[j][4:0]]);
            end
            check("analog", {o_analog.drive, o_analog.diode, 2'b00, o_analog.gain},
                  mdl[5'h0F]);
        end
        i_light_en = 1;
        for (int k = 0; k < 3; k++) begin
            v = rnd();
            #0 {i_result.ch0, i_result.ch1, i_result.prox} = {v, v[23:8]};
            e = (k == 0) ? v[31:16] : (k == 1) ? v[15:0] : v[23:8];
            pulse(0);
            rd(8'h14 + 8'(2 * k));
            check("low byte", d, e[7:0]);
            v = rnd();
            {i_result.ch0, i_result.ch1, i_result.prox} = {v, v[15:0]};
            pulse(0);
            rd(8'h15 + 8'(2 * k));
            check("high byte", d, e[15:8]);
        end
        i_prox_irq_flag = 1;
        i_result.ch0 = 16'h0010;
        pulse(0);
        rd(8'h13);
        check("status", d, 8'h31);
        check("pin", o_analog.int_n_oe, 1);
        i_prox_irq_flag = 0;
        i_result.ch0 = 16'h2000;
        pulse(1);
        rd(8'h13);
        check("status", d, 8'h01);
        check("pin", o_analog.int_n_oe, 0);
        // Light phase is only visible on the pins while light sensing is enabled
        {i_light_en, i_prox_en, i_wait_en} = 3'b111;
        i_light_integration_setting = 8'hFE;
        u_host.wr(8'h0E, 8'h03);
        u_host.wr(8'h0D, 8'h00);
        measure(len, gap0, np, fol);
        check("light len", len, 40);
        check("pulses", np, 3);
        check("prox follows", fol, 1);
        u_host.wr(8'h0D, 8'h02);
        measure(len, gap1, np, fol);
        check("stretch", gap1 - gap0, 11 * 20);
        print_verdict();
    end
endmodule // light_prox_sensor_regs_test
